/* design/ist_top.sv */
// stop condition trigger control with register port and serial line drive
//
// Summary of operation
// - trigger drives sda low, scl high, sda rises
// - eighth-clock wait: stop during ninth high
// - repeated set writes ignored until cleared
// - cleared on loss, stop, release, disable, reset
// - wait release in transmit at the ninth clock clears transmit, frees sda
// - stop and start triggers read back zero
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module ist_top (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	// unit events from the surrounding serial engine
	input wire logic master_mode,
	input wire logic arb_lost,
	input wire logic transmit_set,
	input wire logic ninth_clock,
	input wire logic wait_eighth,
	// serial clock line, open drain
	input wire logic serial_clock_line_i,
	output logic serial_clock_line_o,
	output logic serial_clock_line_oe_n,
	// serial data line, open drain
	input wire logic serial_data_line_i,
	output logic serial_data_line_o,
	output logic serial_data_line_oe_n,
	// stop state
	output logic stop_trigger_o,
	output logic stop_detected_o
);
	logic [1:0] scl_sync_q;
	logic [1:0] sda_sync_q;
	logic scl_q;
	logic sda_q;
	ist_pkg::ist_lines_t lines;
	logic stop_trigger_q;
	logic ack_enable_bit_q;
	logic wait_timing_select_q;
	logic unit_enable_bit_q;
	logic reservation_disable_q;
	logic fast_q;
	logic transmit_receive_status_q;
	logic stop_det_q;
	logic arb_lost_q;
	logic sda_free_q;
	logic gen_sda_low;
	logic gen_scl_low;
	logic gen_busy;
	logic gen_busy_q;
	logic stop_seen;
	logic clear_stop;
	logic wr_ctrl;
	logic eighth_stop_q;
	logic gen_launch; // one-cycle start request to the sequencer
	logic unit_enable_next; // enable as it stands after this cycle's write

	// two-stage synchronisers for the bus lines, then a history stage
	always_ff @(posedge clk) begin
		if (rst) begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_sync_q <= {scl_sync_q[0], serial_clock_line_i};
			sda_sync_q <= {sda_sync_q[0], serial_data_line_i};
			scl_q <= scl_sync_q[1];
			sda_q <= sda_sync_q[1];
		end
	end

	// one driver for the whole carrier, scl in the upper field
	assign lines = {scl_sync_q[1], sda_sync_q[1]};
	// stop seen: sda rises while scl high
	assign stop_seen = lines.scl && scl_q && lines.sda && !sda_q;
	assign wr_ctrl = wr && (addr == ist_pkg::ADDR_CTRL);
	// release, disable, arbitration loss and detected stop all drop the trigger
	// enable written in the same write as stop must not cancel that stop
	assign unit_enable_next = wr_ctrl ? wdata[ist_pkg::BIT_EN] : unit_enable_bit_q;
	assign clear_stop = arb_lost || stop_seen || !unit_enable_next
		|| (wr_ctrl && wdata[ist_pkg::BIT_LREL]);

	// configuration bits written by software
	always_ff @(posedge clk) begin
		if (rst) begin
			ack_enable_bit_q <= ist_pkg::CTRL_RESET[ist_pkg::BIT_ACK_ENABLE_BIT];
			wait_timing_select_q <= ist_pkg::CTRL_RESET[ist_pkg::BIT_WTIM];
			unit_enable_bit_q <= ist_pkg::CTRL_RESET[ist_pkg::BIT_EN];
			reservation_disable_q <= ist_pkg::CTRL_RESET[ist_pkg::BIT_RSV];
			fast_q <= ist_pkg::CTRL_RESET[ist_pkg::BIT_FAST];
		end else if (wr_ctrl) begin
			ack_enable_bit_q <= wdata[ist_pkg::BIT_ACK_ENABLE_BIT];
			wait_timing_select_q <= wdata[ist_pkg::BIT_WTIM];
			unit_enable_bit_q <= wdata[ist_pkg::BIT_EN];
			reservation_disable_q <= wdata[ist_pkg::BIT_RSV];
			fast_q <= wdata[ist_pkg::BIT_FAST];
		end
	end

	// stop trigger: only software sets it, hardware events clear it
	always_ff @(posedge clk) begin
		if (rst) begin
			stop_trigger_q <= 1'b0;
		end else if (clear_stop) begin
			stop_trigger_q <= 1'b0;
		end else if (wr_ctrl && wdata[ist_pkg::BIT_STOP] && !stop_trigger_q) begin
			// a write while already set is dropped, no restart of the sequence
			stop_trigger_q <= 1'b1;
		end
	end

	// eighth-clock wait: stop is forced into the ninth clock high phase
	always_ff @(posedge clk) begin
		if (rst || clear_stop) begin
			eighth_stop_q <= 1'b0;
		end else if (wr_ctrl && wdata[ist_pkg::BIT_STOP] && !stop_trigger_q) begin
			eighth_stop_q <= !wait_timing_select_q && wait_eighth;
		end else if (gen_busy) begin
			eighth_stop_q <= 1'b0;
		end
	end

	// an eighth-clock stop keeps its launch back until the ninth clock
	assign gen_launch = stop_trigger_q && !gen_busy_q && (!eighth_stop_q || ninth_clock);

	// launched flag: one sequence per trigger, dropped together with the trigger
	always_ff @(posedge clk) begin
		if (rst) begin
			gen_busy_q <= 1'b0;
		end else begin
			gen_busy_q <= (gen_busy_q || gen_launch) && !clear_stop;
		end
	end

	ist_stop_gen u_gen (
		.clk(clk),
		.rst(rst),
		.start_i(gen_launch),
		.abort_i(clear_stop),
		.fast_i(fast_q),
		.lines_i(lines),
		.sda_low_o(gen_sda_low),
		.scl_low_o(gen_scl_low),
		.busy_o(gen_busy)
	);

	// transmit status and data line release on wait release
	always_ff @(posedge clk) begin
		if (rst || !unit_enable_bit_q) begin
			transmit_receive_status_q <= 1'b0;
			sda_free_q <= 1'b1;
		end else if (transmit_set) begin
			// hardware set wins; the shifter owns the data line until wait release
			transmit_receive_status_q <= 1'b1;
			sda_free_q <= 1'b0;
		end else if (wr_ctrl && wdata[ist_pkg::BIT_WREL] && transmit_receive_status_q
			&& ninth_clock) begin
			transmit_receive_status_q <= 1'b0;
			sda_free_q <= 1'b1;
		end
	end

	// sticky stop-detected and arbitration flags, set wins over clear by read
	always_ff @(posedge clk) begin
		if (rst) begin
			stop_det_q <= 1'b0;
			arb_lost_q <= 1'b0;
		end else begin
			stop_det_q <= stop_seen || (stop_det_q && !(rd && addr == ist_pkg::ADDR_STAT));
			arb_lost_q <= arb_lost || (arb_lost_q && !(rd && addr == ist_pkg::ADDR_STAT));
		end
	end

	// open-drain drive, enable low while pulling low
	always_ff @(posedge clk) begin
		if (rst) begin
			serial_clock_line_o <= 1'b0;
			serial_clock_line_oe_n <= 1'b1;
			serial_data_line_o <= 1'b0;
			serial_data_line_oe_n <= 1'b1;
		end else begin
			serial_clock_line_o <= 1'b0;
			serial_clock_line_oe_n <= !gen_scl_low;
			serial_data_line_o <= 1'b0;
			serial_data_line_oe_n <= !(gen_sda_low && sda_free_q);
		end
	end

	// status outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			stop_trigger_o <= 1'b0;
			stop_detected_o <= 1'b0;
		end else begin
			stop_trigger_o <= stop_trigger_q;
			stop_detected_o <= stop_det_q;
		end
	end

	// read data one cycle after the strobe; trigger bits always read zero
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= 16'h0000;
		end else if (rd && addr == ist_pkg::ADDR_CTRL) begin
			rdata <= 16'h0000;
			rdata[ist_pkg::BIT_STOP] <= 1'b0;
			rdata[ist_pkg::BIT_START] <= 1'b0;
			rdata[ist_pkg::BIT_ACK_ENABLE_BIT] <= ack_enable_bit_q;
			rdata[ist_pkg::BIT_WTIM] <= wait_timing_select_q;
			rdata[ist_pkg::BIT_EN] <= unit_enable_bit_q;
			rdata[ist_pkg::BIT_RSV] <= reservation_disable_q;
			rdata[ist_pkg::BIT_FAST] <= fast_q;
		end else if (rd && addr == ist_pkg::ADDR_STAT) begin
			rdata <= 16'h0000;
			rdata[ist_pkg::ST_MASTER] <= master_mode;
			rdata[ist_pkg::ST_TRC] <= transmit_receive_status_q;
			rdata[ist_pkg::ST_STOPDET] <= stop_det_q;
			rdata[ist_pkg::ST_ARBLOST] <= arb_lost_q;
			rdata[ist_pkg::ST_BUSY] <= gen_busy;
		end else begin
			rdata <= 16'h0000;
		end
	end
endmodule

/* pkg/ist_pkg.sv */
// package for the i2c stop-condition trigger block
package ist_pkg;
	// clock rate and stop setup time
	localparam int CLK_MHZ = 100;
	localparam int STOP_SETUP_NS = 4000;
	localparam int STOP_SETUP_FAST_NS = 600;
	localparam int STOP_SETUP_CYC = (STOP_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int STOP_SETUP_FAST_CYC = (STOP_SETUP_FAST_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 10;
	// register offsets
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STAT = 4'h1;
	// control register bit positions
	localparam int BIT_STOP = 0;
	localparam int BIT_START = 1;
	localparam int BIT_ACK_ENABLE_BIT = 2;
	localparam int BIT_WTIM = 3;
	localparam int BIT_LREL = 4;
	localparam int BIT_WREL = 5;
	localparam int BIT_EN = 6;
	localparam int BIT_RSV = 7;
	localparam int BIT_FAST = 8;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	// status bit positions
	localparam int ST_MASTER = 0;
	localparam int ST_TRC = 1;
	localparam int ST_STOPDET = 2;
	localparam int ST_ARBLOST = 3;
	localparam int ST_BUSY = 4;
	// stop generator states
	typedef enum logic [2:0] {
		IST_IDLE,
		IST_SDA_LOW,
		IST_SCL_REL,
		IST_SETUP,
		IST_SDA_REL
	} ist_state_t;
	// sampled bus lines
	typedef struct packed {
		logic scl;
		logic sda;
	} ist_lines_t;
endpackage

/* design/ist_stop_gen.sv */
// stop condition sequencer that drives the serial lines
`timescale 1ns/10ps
module ist_stop_gen (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic start_i,
	input wire logic abort_i,
	input wire logic fast_i,
	input wire ist_pkg::ist_lines_t lines_i,
	// line drive requests and state
	output logic sda_low_o,
	output logic scl_low_o,
	output logic busy_o
);
	ist_pkg::ist_state_t state_q;
	logic [ist_pkg::CNT_W-1:0] cnt_q;
	logic [ist_pkg::CNT_W-1:0] setup_cyc;

	// setup interval follows the chosen bus speed
	assign setup_cyc = fast_i ? ist_pkg::CNT_W'(ist_pkg::STOP_SETUP_FAST_CYC)
		: ist_pkg::CNT_W'(ist_pkg::STOP_SETUP_CYC);

	// sequence: pull sda low, release scl, wait setup, release sda
	always_ff @(posedge clk) begin
		if (rst || abort_i) begin
			state_q <= ist_pkg::IST_IDLE;
			cnt_q <= '0;
		end else begin
			case (state_q)
				ist_pkg::IST_IDLE: begin
					if (start_i) begin
						state_q <= ist_pkg::IST_SDA_LOW;
					end
				end
				ist_pkg::IST_SDA_LOW: begin
					// sda low while scl still low, so no false start
					if (!lines_i.sda) begin
						state_q <= ist_pkg::IST_SCL_REL;
					end
				end
				ist_pkg::IST_SCL_REL: begin
					// clock stretching by a slave is honoured here
					if (lines_i.scl) begin
						state_q <= ist_pkg::IST_SETUP;
						cnt_q <= '0;
					end
				end
				ist_pkg::IST_SETUP: begin
					if (cnt_q >= setup_cyc - 1'b1) begin
						state_q <= ist_pkg::IST_SDA_REL;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				ist_pkg::IST_SDA_REL: begin
					state_q <= ist_pkg::IST_IDLE;
				end
				default: begin
					state_q <= ist_pkg::IST_IDLE;
				end
			endcase
		end
	end

	// line requests from state
	assign sda_low_o = (state_q == ist_pkg::IST_SDA_LOW) || (state_q == ist_pkg::IST_SCL_REL)
		|| (state_q == ist_pkg::IST_SETUP);
	assign scl_low_o = (state_q == ist_pkg::IST_SDA_LOW);
	assign busy_o = (state_q != ist_pkg::IST_IDLE);
endmodule

/* sim/ist_top_props.sv */
// concurrent checks on the stop trigger block ports
`timescale 1ns/10ps
module ist_top_props (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] rdata,
	// unit events and lines
	input wire logic arb_lost,
	input wire logic wait_eighth,
	input wire logic serial_clock_line_i,
	input wire logic serial_data_line_oe_n,
	input wire logic stop_trigger_o,
	input wire logic stop_detected_o
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic [9:0] hi_q; // cycles the clock pin has stayed high, saturating
	logic ctl_wr; // control register write
	assign ctl_wr = wr && (addr == ist_pkg::ADDR_CTRL);
	// count the high phase so the setup span can be judged on the pin itself
	always_ff @(posedge clk) begin
		if (rst || !serial_clock_line_i) begin
			hi_q <= 10'h000;
		end else if (hi_q != 10'h3ff) begin
			hi_q <= hi_q + 10'h001;
		end
	end
	sequence s_sda_held;
		!serial_data_line_oe_n;
	endsequence
	sequence s_trig_gone;
		##[1:2] !stop_trigger_o;
	endsequence
	a_set_by_write: assert property ($rose(stop_trigger_o) |-> $past(ctl_wr, 2) && $past(wdata[0], 2))
		else $error("trigger rose without a write");
	a_sda_low_first: assert property ($rose(stop_trigger_o) && !wait_eighth |-> ##[1:3] s_sda_held)
		else $error("data line not pulled low after trigger");
	a_setup_span: assert property ($rose(serial_data_line_oe_n) && serial_clock_line_i |-> hi_q >= 10'h03c)
		else $error("data line released too soon after clock high");
	a_arb_clears: assert property (arb_lost |-> s_trig_gone)
		else $error("trigger kept after arbitration loss");
	a_release_clears: assert property (ctl_wr && (wdata[4] || !wdata[6]) |-> s_trig_gone)
		else $error("trigger kept after release or disable");
	a_det_clears: assert property ($rose(stop_detected_o) |-> ##[0:2] !stop_trigger_o)
		else $error("trigger kept after stop detected");
	a_read_zero: assert property (rd && addr == ist_pkg::ADDR_CTRL |=> rdata[1:0] == 2'h0)
		else $error("trigger bits read back as one");
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
		else $error("read data outside the read cycle");
endmodule

/* sim/ist_bus_partner.sv */
// far-side bus device: pull-ups and a slow clock stretcher
`timescale 1ns/10ps
module ist_bus_partner (
	// line drive from the block, low pulls the line down
	input wire logic scl_oe_n,
	input wire logic sda_oe_n,
	// stretch length in link clock periods
	input wire logic [3:0] stretch,
	// resolved lines
	output logic scl,
	output logic sda
);
	logic lclk = 1'b0; // link clock, 160 ns, phase unrelated to the block clock
	logic [3:0] hold_q = 4'h0; // periods left to keep the clock low
	initial begin
		#3;
		forever #80 lclk = ~lclk;
	end
	// load on any pull-down, even one shorter than a link period
	always @(posedge lclk or negedge scl_oe_n) begin
		if (!scl_oe_n) hold_q <= stretch;
		else if (hold_q != 4'h0) hold_q <= hold_q - 4'h1;
	end
	// the block must wait for this release before timing the setup
	assign scl = scl_oe_n && (hold_q == 4'h0);
	assign sda = sda_oe_n;
endmodule

/* sim/ist_top_tb_top.sv */
// self-checking bench for the stop trigger block
`timescale 1ns/10ps
module ist_top_tb_top;
	logic clk, rst, wr, rd, rd_d, arb_lost, ninth_clock, wait_eighth, transmit_set, master_mode;
	logic [3:0] addr, stretch;
	logic [15:0] wdata, rdata;
	logic scl, sda, scl_oe_n, sda_oe_n, trig;
	logic scl_o, sda_o, det;
	logic [15:0] exp_q[$]; // expected read data, oldest first
	logic [31:0] seed = 32'h0000b512; // 46354
	int n_mismatch = 0;
	int checked = 0;
	int n;
	ist_top u_ist_top (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .master_mode, .arb_lost,
		.transmit_set, .ninth_clock, .wait_eighth, .serial_clock_line_i(scl),
		.serial_clock_line_o(scl_o), .serial_clock_line_oe_n(scl_oe_n), .serial_data_line_i(sda),
		.serial_data_line_o(sda_o), .serial_data_line_oe_n(sda_oe_n), .stop_trigger_o(trig),
		.stop_detected_o(det));
	ist_bus_partner u_ist_bus_partner (.scl_oe_n, .sda_oe_n, .stretch, .scl, .sda);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function logic [3:0] nxt();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[3:0];
	endfunction
	task check(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task complete_run;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// one-cycle strobes; the trailing edge keeps back-to-back calls race free
	task wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd_reg(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	always @(posedge clk) begin
		rd_d <= rd;
		if (rd_d) check(rdata, exp_q.pop_front());
	end
	task wait_oe(input logic v);
		for (n = 0; n < 2000 && sda_oe_n !== v; n++) @(posedge clk);
		check({15'h0, sda_oe_n}, {15'h0, v});
	endtask
	// full stop: setup counted over the clock pin's high phase only
	task run_stop(input logic fast);
		int setup;
		setup = fast ? ist_pkg::STOP_SETUP_FAST_CYC : ist_pkg::STOP_SETUP_CYC;
		stretch <= nxt();
		wr_reg(ist_pkg::ADDR_CTRL, {7'h00, fast, 8'h41});
		wr_reg(ist_pkg::ADDR_CTRL, {7'h00, fast, 8'h41});
		rd_reg(ist_pkg::ADDR_CTRL, {7'h00, fast, 8'h40});
		n = 0;
		while (sda_oe_n !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n = scl ? n + 1 : 0;
		end
		check({15'h0, n >= setup && n <= setup + 6}, 16'h0001);
		repeat (10) @(posedge clk);
		check({15'h0, trig}, 16'h0000);
		check({15'h0, det}, 16'h0001);
		rd_reg(ist_pkg::ADDR_STAT, 16'h0005);
		rd_reg(ist_pkg::ADDR_STAT, 16'h0001);
	endtask
	initial begin
		rst = 1'b1;
		{wr, rd, arb_lost, ninth_clock, wait_eighth, transmit_set} = 6'h00;
		master_mode = 1'b1;
		addr = 4'h0;
		wdata = 16'h0000;
		stretch = 4'h0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1 check({10'h0, det, scl_o, sda_o, scl_oe_n, sda_oe_n, trig}, 16'h0006);
		rd_reg(4'h7, 16'h0000);
		run_stop(1'b1);
		run_stop(1'b0);
		// wait release in transmit during the ninth clock
		transmit_set <= 1'b1;
		ninth_clock <= 1'b1;
		@(posedge clk);
		transmit_set <= 1'b0;
		rd_reg(ist_pkg::ADDR_STAT, 16'h0003);
		wr_reg(ist_pkg::ADDR_CTRL, 16'h0068);
		rd_reg(ist_pkg::ADDR_STAT, 16'h0001);
		check({15'h0, sda_oe_n}, 16'h0001);
		// stop in the eighth-clock wait is held back to the ninth clock
		ninth_clock <= 1'b0;
		wait_eighth <= 1'b1;
		// wait timing back to the eighth clock before the stop is written
		wr_reg(ist_pkg::ADDR_CTRL, 16'h0040);
		wr_reg(ist_pkg::ADDR_CTRL, 16'h0041);
		repeat (8) @(posedge clk);
		check({15'h0, sda_oe_n}, 16'h0001);
		ninth_clock <= 1'b1;
		wait_oe(1'b0);
		wait_oe(1'b1);
		wait_eighth <= 1'b0;
		ninth_clock <= 1'b0;
		repeat (10) @(posedge clk);
		rd_reg(ist_pkg::ADDR_STAT, 16'h0005);
		// aborts while the partner holds the clock low
		stretch <= 4'hf;
		for (int k = 0; k < 3; k++) begin
			wr_reg(ist_pkg::ADDR_CTRL, 16'h0041);
			repeat (20) @(posedge clk);
			if (k == 0) arb_lost <= 1'b1;
			else wr_reg(ist_pkg::ADDR_CTRL, k == 1 ? 16'h0050 : 16'h0000);
			@(posedge clk);
			arb_lost <= 1'b0;
			repeat (3) @(posedge clk);
			#1 check({15'h0, trig}, 16'h0000);
			repeat (400) @(posedge clk);
		end
		complete_run();
	end
	// cut a hang short
	initial begin
		#200000;
		n_mismatch++;
		complete_run();
	end
endmodule
bind ist_top ist_top_props u_ist_top_props (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
	.arb_lost, .wait_eighth, .serial_clock_line_i, .serial_data_line_oe_n, .stop_trigger_o,
	.stop_detected_o);
